/* rtl/sram_port_pkg.sv */
// Shared types and constants for the synchronous burst memory port.
package sram_port_pkg;
    // ==========================================
    // Geometry
    // ==========================================
    localparam int ADDR_W = 20;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * 8;
    localparam int BURST_W = 2;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
    localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
    localparam logic [LANES-1:0] ALL_LANES = 4'hF;
    localparam logic [LANES-1:0] NO_LANES = 4'h0;

    // ==========================================
    // Control bundle sampled at each rising edge
    // ==========================================
    typedef struct packed {
        logic processor_addr_strobe_n;
        logic controller_addr_strobe_n;
        logic burst_advance_n;
        logic all_bytes_write_n;
        logic byte_lane_write_enable_n;
        logic [LANES-1:0] byte_lane_select_n;
        logic chip_select_one_n;
        logic chip_select_two;
        logic chip_select_three_n;
    } ctrl_t;

    typedef enum logic [1:0] {
        ACC_NONE,
        ACC_READ,
        ACC_WRITE
    } access_t;
endpackage

/* rtl/burst_counter.sv */
// Two-bit wrapping burst counter with linear or interleaved order.
`timescale 1ns/1ps
module burst_counter
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic load,
    input wire logic [sram_port_pkg::BURST_W-1:0] burst_start_bits,
    input wire logic advance,
    input wire logic linear_order,
    output logic [sram_port_pkg::BURST_W-1:0] burst_offset
);
    logic [sram_port_pkg::BURST_W-1:0] start;
    logic [sram_port_pkg::BURST_W-1:0] count;

    // ==========================================
    // Counter
    // ==========================================
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            start <= sram_port_pkg::BURST_ZERO;
            count <= sram_port_pkg::BURST_ZERO;
        end
        else if (clk_en)
        begin
            if (load)
            begin
                start <= burst_start_bits; // R2
                count <= sram_port_pkg::BURST_ZERO;
            end
            else if (advance)
            begin
                count <= count + sram_port_pkg::BURST_STEP; // R6 R20
            end
        end
    end

    // Linear adds the count, interleaved exclusive-ors it.
    assign burst_offset = linear_order ? start + count : start ^ count; // R18
endmodule // burst_counter

/* rtl/pin_sync.sv */
// Three-stage synchroniser that accepts a change once stages agree.
`timescale 1ns/1ps
module pin_sync
#(
    parameter logic RESET_VALUE = 1'b0
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic pin,
    output logic level
);
    logic meta;
    logic s2;
    logic s3;

    // ==========================================
    // Stages
    // ==========================================
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            meta <= RESET_VALUE;
            s2 <= RESET_VALUE;
            s3 <= RESET_VALUE;
            level <= RESET_VALUE;
        end
        else if (clk_en)
        begin
            meta <= pin;
            s2 <= meta;
            s3 <= s2;
            if (s2 == s3)
            begin
                level <= s3;
            end
        end
    end
endmodule // pin_sync

/* rtl/sync_burst_sram_port.sv */
// Synchronous burst static memory port with byte writes and sleep.
// How it works
// R1: Capture address on strobe with all enables active.
// R2: Load low address bits into burst counter.
// R3: Sampled byte selects, with enable, pick lanes.
// R4: Global write low writes every lane.
// R5: Byte writes only when byte enable low.
// R6: Advance low increments burst address.
// R7: Processor strobe ignored when enable one high.
// R8: Enable two high-active, one and three low.
// R9: Enables checked only on new address loads.
// R10: Both strobes low: processor strobe wins.
// R11: Output enable low drives, high releases lines.
// R12: First read cycle after deselect stays released.
// R13: Sleep high idles the port, keeps data.
// R14: Write data captured at rising edge.
// R15: Read returns the currently addressed location.
// R16: Read data passes an output register.
// R17: Deselect releases the data outputs at once.
// R18: Burst order strap low linear, high interleaved.
// R19: Processor strobe write ignores controls first cycle.
// R20: Burst counter wraps within four locations.
`timescale 1ns/1ps
module sync_burst_sram_port
#(
    parameter int ADDR_W = sram_port_pkg::ADDR_W,
    parameter int LANE_W = sram_port_pkg::LANE_W
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire sram_port_pkg::ctrl_t ctrl,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order_strap,
    input wire logic [sram_port_pkg::LANES*LANE_W-1:0] data_in,
    output logic [sram_port_pkg::LANES*LANE_W-1:0] data_out,
    output logic data_oe_n,
    output logic sleeping
);
    localparam int WORD_W = sram_port_pkg::LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;

    logic [WORD_W-1:0] mem [DEPTH];
    logic [ADDR_W-1:0] addr_reg;
    logic [sram_port_pkg::BURST_W-1:0] burst_offset;
    logic [ADDR_W-1:0] eff_addr;
    logic sleep_sync;
    logic strap_sync;
    logic linear_order;
    logic selected;
    logic first_read;
    logic out_valid;
    logic proc_load;
    logic ctrl_load;
    logic load;
    logic deselect;
    logic enables_active;
    logic write_any;
    logic [sram_port_pkg::LANES-1:0] lanes;

    // ==========================================
    // Lane choice from the write controls
    // ==========================================
    function automatic logic [sram_port_pkg::LANES-1:0] lane_mask(
        input sram_port_pkg::ctrl_t c
    );
        if (!c.all_bytes_write_n)
            lane_mask = sram_port_pkg::ALL_LANES; // R4
        else if (!c.byte_lane_write_enable_n)
            lane_mask = ~c.byte_lane_select_n; // R3 R5
        else
            lane_mask = sram_port_pkg::NO_LANES;
    endfunction

    // ==========================================
    // Asynchronous pin synchronisers
    // ==========================================
    pin_sync #(.RESET_VALUE(1'b0)) sleep_pin
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin(sleep_request),
        .level(sleep_sync)
    );

    pin_sync #(.RESET_VALUE(1'b1)) strap_pin
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin(burst_order_strap),
        .level(strap_sync)
    );

    // The strap is static, so its settled level is simply followed.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            linear_order <= 1'b0;
        else if (clk_en)
            linear_order <= ~strap_sync; // R18
    end

    // ==========================================
    // Address load decode
    // ==========================================
    always_comb
    begin
        enables_active = !ctrl.chip_select_one_n && ctrl.chip_select_two
            && !ctrl.chip_select_three_n; // R8 R9
        proc_load = !ctrl.processor_addr_strobe_n
            && !ctrl.chip_select_one_n; // R7 R10
        ctrl_load = !proc_load && !ctrl.controller_addr_strobe_n; // R10
        load = (proc_load || ctrl_load) && enables_active && !sleep_sync; // R1
        deselect = (proc_load || ctrl_load) && !enables_active; // R17
        lanes = lane_mask(ctrl);
        write_any = lanes != sram_port_pkg::NO_LANES;
    end

    burst_counter counter
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en && !sleep_sync),
        .load(load),
        .burst_start_bits(addr[sram_port_pkg::BURST_W-1:0]),
        .advance(!load && !ctrl.burst_advance_n && selected), // R6 R19
        .linear_order(linear_order),
        .burst_offset(burst_offset)
    );

    assign eff_addr = {addr_reg[ADDR_W-1:sram_port_pkg::BURST_W],
        burst_offset}; // R15 R20

    // ==========================================
    // Access state
    // ==========================================
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            addr_reg <= '0;
            selected <= 1'b0;
        end
        else if (clk_en && !sleep_sync) // R13
        begin
            if (load)
            begin
                addr_reg <= addr; // R1
                selected <= 1'b1;
            end
            else if (deselect)
            begin
                selected <= 1'b0; // R17
            end
        end
    end

    // ==========================================
    // Array write and read with output register
    // ==========================================
    always_ff @(posedge ref_clk)
    begin
        if (clk_en && !sleep_sync && selected && !load && !deselect) // R19
        begin
            for (int i = 0; i < sram_port_pkg::LANES; i++)
            begin
                if (lanes[i])
                    mem[eff_addr][i*LANE_W +: LANE_W]
                        <= data_in[i*LANE_W +: LANE_W]; // R14 R3 R4
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            data_out <= '0;
            out_valid <= 1'b0;
            first_read <= 1'b0;
        end
        else if (clk_en && !sleep_sync)
        begin
            if (deselect)
            begin
                out_valid <= 1'b0; // R17
                first_read <= 1'b0;
            end
            else if (load && (proc_load || !write_any)) // R19
            begin
                data_out <= mem[addr]; // R16
                out_valid <= 1'b1;
                first_read <= !selected; // R12
            end
            else if (selected && !load && !write_any)
            begin
                data_out <= mem[eff_addr]; // R15 R16
                out_valid <= 1'b1;
                first_read <= 1'b0;
            end
            else if (!load)
            begin
                out_valid <= 1'b0;
                first_read <= 1'b0;
            end
        end
    end

    // Output enable acts without the clock on the line drivers.
    assign data_oe_n = output_enable_n || !out_valid || first_read; // R11 R12
    assign sleeping = sleep_sync; // R13
endmodule // sync_burst_sram_port

/* test/host_data_model.sv */
// Host side of the shared data and parity lines.
`timescale 1ns/1ps
module host_data_model
(
    input wire logic ref_clk,
    input wire logic host_drive,
    input wire logic [35:0] host_data,
    input wire logic [35:0] dev_data,
    input wire logic dev_oe_n,
    output logic [35:0] bus
);
    logic [35:0] last = 36'h0_0000_0000;
    always_comb
    begin
        if (host_drive)
            bus = host_data;
        else if (!dev_oe_n)
            bus = dev_data;
        else
            bus = ~last;
    end
    always @(posedge ref_clk)
        last <= bus;
endmodule // host_data_model

/* test/sync_burst_sram_port_monitor.sv */
// Pin level checks for the burst memory port.
`timescale 1ns/1ps
module sync_burst_sram_port_monitor
#(
    parameter int ADDR_W = sram_port_pkg::ADDR_W,
    parameter int LANE_W = sram_port_pkg::LANE_W
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire sram_port_pkg::ctrl_t ctrl,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order_strap,
    input wire logic [sram_port_pkg::LANES*LANE_W-1:0] data_in,
    input wire logic [sram_port_pkg::LANES*LANE_W-1:0] data_out,
    input wire logic data_oe_n,
    input wire logic sleeping
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic live;
    assign live = clk_en && !sleeping;
    sequence read_load;
        live && !ctrl.controller_addr_strobe_n && ctrl.processor_addr_strobe_n
        && !ctrl.chip_select_one_n && ctrl.chip_select_two
        && !ctrl.chip_select_three_n && ctrl.all_bytes_write_n
        && ctrl.byte_lane_write_enable_n;
    endsequence
    sequence drop_load;
        live && !ctrl.controller_addr_strobe_n && !ctrl.chip_select_two;
    endsequence
    sequence quiet;
        ctrl.controller_addr_strobe_n && ctrl.processor_addr_strobe_n;
    endsequence
    oe_release_a: assert property (output_enable_n |-> data_oe_n)
        else $error("driving with output enable high");
    deselect_off_a: assert property (drop_load |=> data_oe_n)
        else $error("driving after deselect");
    deselect_hold_a: assert property (
        drop_load ##1 quiet [*2] |=> data_oe_n)
        else $error("driving while deselected");
    first_read_a: assert property (
        drop_load ##1 read_load |=> data_oe_n)
        else $error("first read cycle not masked");
    read_drive_a: assert property (
        read_load [*3] |-> output_enable_n || !data_oe_n)
        else $error("read data not driven");
    sleep_enter_a: assert property (
        (sleep_request && clk_en) [*8] |-> sleeping)
        else $error("sleep not entered");
    sleep_leave_a: assert property (
        (!sleep_request && clk_en) [*8] |-> !sleeping)
        else $error("sleep not left");
    sleep_hold_a: assert property (sleeping [*3] |-> $stable(data_out))
        else $error("read data moved while asleep");
endmodule // sync_burst_sram_port_monitor
bind sync_burst_sram_port sync_burst_sram_port_monitor
    #(.ADDR_W(ADDR_W), .LANE_W(LANE_W)) mon_u (.ref_clk(ref_clk),
    .rst_n(rst_n), .clk_en(clk_en), .addr(addr), .ctrl(ctrl),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request),
    .burst_order_strap(burst_order_strap), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .sleeping(sleeping));

/* test/sync_burst_sram_port_test.sv */
// Self-checking bench for the burst memory port.
`timescale 1ns/1ps
module sync_burst_sram_port_test;
    // ==========================================
    // Signals and instances
    // ==========================================
    typedef logic [35:0] word_t;
    localparam sram_port_pkg::ctrl_t IDLE = '1;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [19:0] addr = 20'h0_0000;
    sram_port_pkg::ctrl_t ctrl = '1;
    logic output_enable_n = 1'b1;
    logic sleep_request = 1'b0;
    logic clk_en = 1'b1;
    logic en_q = 1'b1;
    logic burst_order_strap = 1'b0;
    word_t host_data = 36'h0_0000_0000;
    word_t data_in, data_out, d_q;
    logic data_oe_n, sleeping, oe_q;
    word_t m [int];
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    always #5 ref_clk = ~ref_clk;
    sync_burst_sram_port dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
        .clk_en(clk_en), .addr(addr), .ctrl(ctrl),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request),
        .burst_order_strap(burst_order_strap), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .sleeping(sleeping));
    host_data_model host_u (.ref_clk(ref_clk), .host_drive(output_enable_n),
        .host_data(host_data), .dev_data(data_out), .dev_oe_n(data_oe_n),
        .bus(data_in));
    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            complete_run();
        end
    end
    task automatic check(input word_t got, input word_t exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic step(input sram_port_pkg::ctrl_t c, input logic [19:0] a);
        @(negedge ref_clk);
        ctrl = c;
        addr = a;
        clk_en = en_q;
        output_enable_n = oe_q;
        host_data = d_q;
        @(posedge ref_clk);
        #1;
    endtask
    function automatic sram_port_pkg::ctrl_t load(input logic p);
        sram_port_pkg::ctrl_t c;
        c = IDLE;
        c.processor_addr_strobe_n = ~p;
        c.controller_addr_strobe_n = 1'b0;
        c.chip_select_one_n = 1'b0;
        c.chip_select_three_n = 1'b0;
        return c;
    endfunction
    task automatic wr(input logic [19:0] a, input word_t d,
        input logic [3:0] sel_n, input logic gw_n, input logic bwe_n,
        input logic p);
        sram_port_pkg::ctrl_t c;
        oe_q = 1'b1;
        d_q = d;
        c = load(p);
        c.all_bytes_write_n = ~p;
        step(c, a);
        c = IDLE;
        c.all_bytes_write_n = gw_n;
        c.byte_lane_write_enable_n = bwe_n;
        c.byte_lane_select_n = sel_n;
        step(c, a);
        for (int i = 0; i < 4; i++)
            if (!gw_n || (!bwe_n && !sel_n[i]))
                m[a][i*9+:9] = d[i*9+:9];
    endtask
    task automatic rd(input logic [19:0] a, input int n, input logic [7:0] s);
        sram_port_pkg::ctrl_t c;
        oe_q = 1'b0;
        step(load(1'b0), a);
        for (int i = 0; i < n; i++)
        begin
            c = IDLE;
            c.burst_advance_n = (i == n - 1);
            step(c, a);
            check(data_out, m[{a[19:2], s[2*i+:2]}]);
        end
    endtask
    // ==========================================
    // Scenarios
    // ==========================================
    task automatic t_order();
        @(negedge ref_clk);
        burst_order_strap = 1'b1;
        repeat (6) step(IDLE, 20'h0_0000);
        rd(20'h0_0041, 4, 8'hB1);
        @(negedge ref_clk);
        burst_order_strap = 1'b0;
        repeat (6) step(IDLE, 20'h0_0000);
    endtask
    task automatic t_lanes();
        wr(20'h0_0042, 36'h0_0000_0000, 4'hA, 1'b1, 1'b0, 1'b0);
        wr(20'h0_0043, 36'h0_0000_0000, 4'h0, 1'b1, 1'b1, 1'b0);
        wr(20'h0_0040, 36'h0_0000_0000, 4'hF, 1'b1, 1'b1, 1'b1);
        wr(20'h0_0041, 36'hF_FFFF_FFFF, 4'h0, 1'b0, 1'b1, 1'b1);
        rd(20'h0_0040, 4, 8'hE4);
    endtask
    task automatic t_select();
        sram_port_pkg::ctrl_t c;
        oe_q = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            c = load(1'b0);
            c[i] = ~c[i];
            step(c, 20'h0_0041);
            check(36'(data_oe_n), 36'h1);
            step(load(1'b0), 20'h0_0041);
            check(36'(data_oe_n), 36'h1);
        end
        step(load(1'b0), 20'h0_0041);
        step(load(1'b0), 20'h0_0041);
        check(36'(data_oe_n), 36'h0);
        c = IDLE;
        c.processor_addr_strobe_n = 1'b0;
        step(c, 20'h0_0043);
        step(IDLE, 20'h0_0043);
        check(data_out, m[20'h0_0041]);
        check(36'(data_oe_n), 36'h0);
        c = load(1'b0);
        c.chip_select_one_n = 1'b1;
        step(c, 20'h0_0042);
        c.chip_select_one_n = 1'b0;
        c.chip_select_two = 1'b0;
        step(c, 20'h0_0041);
        repeat (2) step(IDLE, 20'h0_0042);
        check(36'(data_oe_n), 36'h1);
    endtask
    task automatic t_sleep();
        @(negedge ref_clk);
        sleep_request = 1'b1;
        repeat (10) step(IDLE, 20'h0_0040);
        check(36'(sleeping), 36'h1);
        step(load(1'b0), 20'h0_0042);
        step(IDLE, 20'h0_0042);
        check(data_out, m[20'h0_0041]);
        @(negedge ref_clk);
        sleep_request = 1'b0;
        repeat (10) step(IDLE, 20'h0_0040);
        check(36'(sleeping), 36'h0);
        rd(20'h0_0040, 4, 8'hE4);
    endtask
    task automatic t_freeze();
        sram_port_pkg::ctrl_t c;
        c = IDLE;
        c.burst_advance_n = 1'b0;
        oe_q = 1'b0;
        step(load(1'b1), 20'h0_0042);
        step(c, 20'h0_0042);
        check(data_out, m[20'h0_0042]);
        en_q = 1'b0;
        repeat (3) step(c, 20'h0_0042);
        check(data_out, m[20'h0_0042]);
        en_q = 1'b1;
        step(c, 20'h0_0042);
        check(data_out, m[20'h0_0043]);
    endtask
    initial
    begin
        oe_q = 1'b1;
        d_q = 36'h0_0000_0000;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (6) step(IDLE, 20'h0_0000);
        for (int i = 64; i < 68; i++)
            wr(20'(i), {4{9'(i)}} ^ 36'hA_5A5A_5A5A, 4'hF, 1'b0, 1'b1, 1'b0);
        rd(20'h0_0041, 4, 8'h39);
        t_order();
        t_lanes();
        t_select();
        t_sleep();
        t_freeze();
        complete_run();
    end
endmodule // sync_burst_sram_port_test
